// ---- bench/atw_table_stage_props.sv ----
// concurrent checks on the ports of the address-table staging block
`timescale 1ns/1ps
module atw_table_stage_props
	import atw_pkg::*;
#(
	parameter int TABLE_DEPTH = ATW_TABLE_DEPTH,
	parameter longint AGE_STEP_CYCLES = ATW_AGE_STEP_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ATW_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic da_valid,
	input wire logic da_result_valid,
	input wire logic da_hit,
	input wire logic [2:0] da_port_mask,
	input wire logic da_override,
	input wire logic da_discard,
	input wire logic [2:0] da_priority,
	input wire logic make_pending
);
	// ==========================================================
	// decode helpers
	localparam logic [15:0] A_CMD = {ATW_IDX_CMD, ATW_WORD_ALIGN};
	localparam logic [15:0] A_LOW = {ATW_IDX_MAC_LOW, ATW_WORD_ALIGN};
	localparam logic [15:0] A_HIGH = {ATW_IDX_MAC_HIGH, ATW_WORD_ALIGN};
	localparam logic [15:0] A_STS = {ATW_IDX_STATUS, ATW_WORD_ALIGN};
	localparam logic [15:0] A_CFG = {ATW_IDX_INGRESS_CFG, ATW_WORD_ALIGN};
	wire logic acc = psel && penable;
	wire logic mapped = paddr inside {A_CMD, A_LOW, A_HIGH, A_STS, A_CFG};
	// a make request only counts while the engine is idle
	wire logic make_req = acc && pwrite && paddr == A_CMD && pwdata[ATW_CMD_MAKE_BIT] && !make_pending;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_make_req;
		make_req;
	endsequence
	sequence s_pend_pulse;
		make_pending ##1 !make_pending;
	endsequence
	// ==========================================================
	// assertions
	a_make_pulse: assert property (s_make_req |=> s_pend_pulse) else $error("make pending not one cycle");
	a_pend_cause: assert property (!make_pending && !make_req |=> !make_pending) else $error("pending without cause");
	a_ready_acc: assert property (acc |-> pready) else $error("no ready in access");
	a_ready_idle: assert property (!acc |-> !pready) else $error("ready outside access");
	a_err_unmap: assert property (acc && !mapped |-> pslverr) else $error("unmapped not refused");
	a_err_none: assert property (acc && mapped |-> !pslverr) else $error("mapped access refused");
	a_res_pulse: assert property (da_valid |=> da_result_valid) else $error("lookup gave no result");
	a_res_cause: assert property (!da_valid |=> !da_result_valid) else $error("result without lookup");
	a_miss_zero: assert property (da_result_valid && !da_hit |-> da_port_mask == 3'h0 && da_priority == 3'h0
		&& !da_discard && !da_override) else $error("miss carries entry fields");
	a_low_back: assert property (acc && pwrite && paddr == A_LOW ##1 !psel ##1 psel && !pwrite && paddr == A_LOW
		##1 penable |-> prdata == $past(pwdata, 3)) else $error("low word read back wrong");
	a_high_rsvd: assert property (acc && !pwrite && paddr == A_HIGH |-> prdata[31:27] == 5'h00)
		else $error("reserved high bits set");
endmodule
bind atw_table_stage atw_table_stage_props #(.TABLE_DEPTH(TABLE_DEPTH), .AGE_STEP_CYCLES(AGE_STEP_CYCLES)) u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .da_valid(da_valid),
	.da_result_valid(da_result_valid), .da_hit(da_hit), .da_port_mask(da_port_mask), .da_override(da_override),
	.da_discard(da_discard), .da_priority(da_priority), .make_pending(make_pending));

// ---- bench/tb_addr_table_entry_write_data.sv ----
// self-checking testbench of the address-table staging block
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_addr_table_entry_write_data;
	import atw_pkg::*;
	// ==========================================================
	// constants and signals
	localparam longint AGE = 20;
	localparam logic [15:0] A_CMD = {ATW_IDX_CMD, ATW_WORD_ALIGN};
	localparam logic [15:0] A_LOW = {ATW_IDX_MAC_LOW, ATW_WORD_ALIGN};
	localparam logic [15:0] A_HIGH = {ATW_IDX_MAC_HIGH, ATW_WORD_ALIGN};
	localparam logic [15:0] A_CFG = {ATW_IDX_INGRESS_CFG, ATW_WORD_ALIGN};
	localparam logic [31:0] VS = 32'h0500_0000; // valid and static
	localparam logic [2:0] MK [8] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sa_valid = 0, da_valid = 0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [47:0] sa_mac = 48'h0000_0000_0000, da_mac = 48'h0000_0000_0000;
	logic pready, pslverr, da_result_valid, da_hit, da_override, da_discard, da_priority_valid, make_pending, er;
	logic [2:0] da_port_mask, da_priority;
	logic [9:0] res;
	int miscompares = 0, check_count = 0;
	always #2 pclk = ~pclk;
	atw_table_stage #(.TABLE_DEPTH(8), .AGE_STEP_CYCLES(AGE)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sa_valid(sa_valid), .sa_mac(sa_mac), .da_valid(da_valid), .da_mac(da_mac),
		.da_result_valid(da_result_valid), .da_hit(da_hit), .da_port_mask(da_port_mask), .da_override(da_override),
		.da_discard(da_discard), .da_priority_valid(da_priority_valid), .da_priority(da_priority),
		.make_pending(make_pending));
	// ==========================================================
	// shared tasks
	task summarize;
		$display("checks=%0d miscompares=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// one apb transfer; request held until ready is seen at an edge
	task apb(input logic [15:0] a, input logic w, input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin miscompares++; summarize(); end
		r = prdata; e = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(a, 1'b1, d, r, e);
	endtask
	// stage both words then fire make entry; bounded wait on pending
	task make(input logic [31:0] w0, input logic [31:0] w1);
		int n;
		wr(A_LOW, w0); wr(A_HIGH, w1); wr(A_CMD, 32'h0000_0004);
		for (n = 0; n < 8; n++) begin @(posedge pclk); if (make_pending === 1'b0) break; end
		if (n == 8) begin miscompares++; summarize(); end
	endtask
	// result is fixed one cycle after the request edge
	task look(input logic [47:0] m, output logic [9:0] r);
		@(posedge pclk); da_valid <= 1'b1; da_mac <= m;
		@(posedge pclk); da_valid <= 1'b0;
		@(negedge pclk); `CHK(da_result_valid, 1'b1)
		r = {da_hit, da_port_mask, da_override, da_discard, da_priority_valid, da_priority};
	endtask
	// ==========================================================
	// scenarios
	task t_regs;
		apb(A_LOW, 1'b0, 32'h0, rd, er); `CHK(rd, 32'h0000_0000)
		apb(A_HIGH, 1'b0, 32'h0, rd, er); `CHK(rd, 32'h0000_0000)
		wr(A_LOW, 32'hA5C3_0F1E); apb(A_LOW, 1'b0, 32'h0, rd, er); `CHK(rd, 32'hA5C3_0F1E)
		wr(A_HIGH, 32'hFFFF_FFFF); apb(A_HIGH, 1'b0, 32'h0, rd, er); `CHK(rd, 32'h07FF_FFFF)
		apb(16'h6100, 1'b0, 32'h0, rd, er); `CHK({er, rd}, {1'b1, 32'h0000_0000})
		apb(16'h6006, 1'b1, 32'h0, rd, er); `CHK(er, 1'b1)
		$display("test regs done");
	endtask
	// every port code, then a flipped multicast bit and a delete
	task t_ports;
		logic [31:0] w0, w1;
		for (int c = 0; c < 8; c++) begin
			w0 = 32'h0000_1100 | c;
			w1 = VS | 32'h0000_8001 | (c << 16);
			make(w0, w1);
			look({w1[15:0], w0}, res); `CHK(res, {1'b1, MK[c], 6'h00})
			look({w1[15:0], w0 ^ 32'h0000_0001}, res); `CHK(res, 10'h000)
			make(w0, w1 & 32'hFBFF_FFFF);
			look({w1[15:0], w0}, res); `CHK(res, 10'h000)
		end
		$display("test ports done");
	endtask
	task t_flags;
		wr(A_CFG, 32'h0000_0001);
		make(32'h0000_0042, 32'h07EF_00FE);
		look({16'h00FE, 32'h0000_0042}, res); `CHK(res, {1'b1, 3'h7, 3'h7, 3'h5})
		wr(A_CFG, 32'h0000_0000);
		look({16'h00FE, 32'h0000_0042}, res); `CHK(res, {1'b1, 3'h7, 3'h6, 3'h5})
		wr(A_CFG, 32'h0000_0001);
		make(32'h0000_0043, 32'h0699_00FE);
		look({16'h00FE, 32'h0000_0043}, res); `CHK(res, {1'b1, 3'h2, 3'h0, 3'h3})
		$display("test flags done");
	endtask
	// one idle entry ages out, a static one stays, a refreshed one stays
	task t_age;
		make(32'h0000_0051, 32'h0680_0A00);
		make(32'h0000_0052, 32'h0500_0A00);
		make(32'h0000_0053, 32'h0680_0A00);
		look({16'h0A00, 32'h0000_0051}, res); `CHK(res, {1'b1, 3'h1, 6'h00})
		for (int i = 0; i < 5; i++) begin
			repeat (AGE) @(posedge pclk);
			sa_valid <= 1'b1; sa_mac <= {16'h0A00, 32'h0000_0053};
			@(posedge pclk); sa_valid <= 1'b0;
		end
		look({16'h0A00, 32'h0000_0051}, res); `CHK(res, 10'h000)
		look({16'h0A00, 32'h0000_0052}, res); `CHK(res, {1'b1, 3'h1, 6'h00})
		look({16'h0A00, 32'h0000_0053}, res); `CHK(res, {1'b1, 3'h1, 6'h00})
		$display("test age done");
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_ports();
		t_flags();
		t_age();
		summarize();
	end
endmodule

// ---- core/atw_age_tick.sv ----
// divider giving a one-cycle aging step enable
`timescale 1ns/1ps
module atw_age_tick #(
	parameter longint PERIOD = atw_pkg::ATW_AGE_STEP_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic tick
);
	import atw_pkg::*;

	initial begin
		if (PERIOD < 1) begin
			$error("aging step period must be at least one cycle");
		end
	end

	logic [63:0] count_q;
	logic [63:0] count_d;
	logic wrap;

	// ==========================================================
	// free-running count; wraps once per period
	assign wrap = (count_q == 64'(PERIOD - 1));
	assign count_d = wrap ? 64'h0000_0000_0000_0000 : count_q + 64'h0000_0000_0000_0001;
	assign tick = wrap;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= 64'h0000_0000_0000_0000;
		end else begin
			count_q <= count_d;
		end
	end
endmodule

// ---- core/atw_pkg.sv ----
// constants shared by the address-table write staging block
package atw_pkg;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [13:0] ATW_IDX_CMD = 14'h1800;
	localparam logic [13:0] ATW_IDX_MAC_LOW = 14'h1801;
	localparam logic [13:0] ATW_IDX_MAC_HIGH = 14'h1802;
	localparam logic [13:0] ATW_IDX_STATUS = 14'h1803;
	localparam logic [13:0] ATW_IDX_INGRESS_CFG = 14'h1810;
	localparam int ATW_ADDR_W = 16;
	localparam logic [1:0] ATW_WORD_ALIGN = 2'h0;

	// ==========================================================
	// field positions of the second staging word
	localparam int ATW_MAC_HI_MSB = 15;
	localparam int ATW_PORT_LSB = 16;
	localparam int ATW_PORT_MSB = 18;
	localparam int ATW_PRI_LSB = 19;
	localparam int ATW_PRI_MSB = 21;
	localparam int ATW_PRI_EN_BIT = 22;
	localparam int ATW_AGE0_BIT = 23;
	localparam int ATW_STATIC_BIT = 24;
	localparam int ATW_AGE1_BIT = 25;
	localparam int ATW_VALID_BIT = 26;
	localparam int ATW_HIGH_W = 27;
	localparam int ATW_MAC_W = 48;

	// command, status and configuration bits
	localparam int ATW_CMD_MAKE_BIT = 2;
	localparam int ATW_STS_PEND_BIT = 0;
	localparam int ATW_STS_FULL_BIT = 1;
	localparam int ATW_CFG_DA_PRI_BIT = 0;

	// reset values and aging codes
	localparam logic [31:0] ATW_MAC_LOW_RST = 32'h0000_0000;
	localparam logic [26:0] ATW_HIGH_RST = 27'h000_0000;
	localparam logic [1:0] ATW_AGE_FULL = 2'h3;
	localparam logic [1:0] ATW_AGE_EXPIRED = 2'h0;

	// ==========================================================
	// timing: one aging step every 2.5 minutes at 250 MHz
	localparam longint ATW_CLK_KHZ = 250000;
	localparam longint ATW_AGE_STEP_MS = 150000;
	localparam longint ATW_AGE_STEP_CYCLES = ATW_AGE_STEP_MS * ATW_CLK_KHZ;
	localparam int ATW_TABLE_DEPTH = 512;

	typedef enum logic [0:0] {
		ATW_ST_IDLE,
		ATW_ST_APPLY
	} atw_state_type;

endpackage

// ---- core/atw_port_decode.sv ----
// decode of the three-bit associated-port code into a port mask
`timescale 1ns/1ps
module atw_port_decode (
	input wire logic [2:0] code,
	output logic [2:0] port_mask,
	output logic reserved
);
	// ==========================================================
	// code to mask; the reserved code selects no port
	always_comb begin
		reserved = 1'b0;
		case (code)
			3'h0: port_mask = 3'h1;
			3'h1: port_mask = 3'h2;
			3'h2: port_mask = 3'h4;
			3'h3: begin
				port_mask = 3'h0;
				reserved = 1'b1;
			end
			3'h4: port_mask = 3'h3;
			3'h5: port_mask = 3'h5;
			3'h6: port_mask = 3'h6;
			3'h7: port_mask = 3'h7;
			default: port_mask = 3'h0;
		endcase
	end
endmodule

// ---- core/atw_table_stage.sv ----
// address-table write staging registers, make-entry engine and table
`timescale 1ns/1ps
module atw_table_stage #(
	parameter int TABLE_DEPTH = atw_pkg::ATW_TABLE_DEPTH,
	parameter longint AGE_STEP_CYCLES = atw_pkg::ATW_AGE_STEP_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [atw_pkg::ATW_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sa_valid,
	input wire logic [atw_pkg::ATW_MAC_W-1:0] sa_mac,
	input wire logic da_valid,
	input wire logic [atw_pkg::ATW_MAC_W-1:0] da_mac,
	output logic da_result_valid,
	output logic da_hit,
	output logic [2:0] da_port_mask,
	output logic da_override,
	output logic da_discard,
	output logic da_priority_valid,
	output logic [2:0] da_priority,
	output logic make_pending
);
	import atw_pkg::*;

	localparam int IDX_W = $clog2(TABLE_DEPTH);

	// table sizing notes:
	// every entry carries three full-width comparators (command, source, destination),
	// so area grows linearly with depth; a ram with a hashed search would be smaller
	// but would need several cycles per lookup, and the lookup here answers in one.
	// a depth that is not a power of two is fine: unused index codes never match.

	initial begin
		if (TABLE_DEPTH < 2) begin
			$error("table depth must be at least two");
		end
		if (AGE_STEP_CYCLES < 1) begin
			$error("aging step must be at least one cycle");
		end
	end

	// ==========================================================
	// apb decode
	// the map holds five word registers; the index is the byte address over four.
	// a misaligned or unknown address is refused with pslverr and has no side effect,
	// so a stray write can never start a command or disturb the staging words.
	// there are no wait states: every access phase completes at its first edge,
	// which is why read data must already be settled when penable rises.
	logic setup_phase;
	logic access_phase;
	logic wr_access;
	logic aligned;
	logic [13:0] reg_idx;
	logic sel_cmd;
	logic sel_mac_low;
	logic sel_mac_high;
	logic sel_status;
	logic sel_cfg;
	logic mapped;
	logic [31:0] rd_word;

	assign setup_phase = psel && !penable;
	assign access_phase = psel && penable;
	assign wr_access = access_phase && pwrite && mapped;
	assign reg_idx = paddr[ATW_ADDR_W-1:2];
	assign aligned = (paddr[1:0] == ATW_WORD_ALIGN);
	assign sel_cmd = aligned && (reg_idx == ATW_IDX_CMD);
	assign sel_mac_low = aligned && (reg_idx == ATW_IDX_MAC_LOW);
	assign sel_mac_high = aligned && (reg_idx == ATW_IDX_MAC_HIGH);
	assign sel_status = aligned && (reg_idx == ATW_IDX_STATUS);
	assign sel_cfg = aligned && (reg_idx == ATW_IDX_INGRESS_CFG);
	assign mapped = sel_cmd || sel_mac_low || sel_mac_high || sel_status || sel_cfg;

	// zero wait states: read data is latched in the setup cycle
	assign pready = access_phase;
	assign pslverr = access_phase && !mapped;

	// ==========================================================
	// staging and configuration registers
	logic [31:0] mac_low_q;
	logic [ATW_HIGH_W-1:0] high_q;
	logic da_pri_global_q;
	logic full_q;
	atw_state_type state_q;
	atw_state_type state_d;
	logic make_start;
	logic [ATW_MAC_W-1:0] cap_mac_q;
	logic [ATW_HIGH_W-1:ATW_PORT_LSB] cap_ctrl_q;

	// staging words stay writable while pending; the engine works from its capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mac_low_q <= ATW_MAC_LOW_RST;
			high_q <= ATW_HIGH_RST;
			da_pri_global_q <= 1'b0;
		end else begin
			if (wr_access && sel_mac_low) begin
				mac_low_q <= pwdata;
			end
			if (wr_access && sel_mac_high) begin
				high_q <= pwdata[ATW_HIGH_W-1:0];
			end
			if (wr_access && sel_cfg) begin
				da_pri_global_q <= pwdata[ATW_CFG_DA_PRI_BIT];
			end
		end
	end

	// readback; reserved bits read as zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (sel_mac_low) begin
			rd_word = mac_low_q;
		end else if (sel_mac_high) begin
			rd_word[ATW_HIGH_W-1:0] = high_q;
		end else if (sel_cmd) begin
			rd_word[ATW_CMD_MAKE_BIT] = make_pending;
		end else if (sel_status) begin
			rd_word[ATW_STS_PEND_BIT] = make_pending;
			rd_word[ATW_STS_FULL_BIT] = full_q;
		end else if (sel_cfg) begin
			rd_word[ATW_CFG_DA_PRI_BIT] = da_pri_global_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase && !pwrite) begin
			prdata <= rd_word;
		end
	end

	// ==========================================================
	// make-entry command: writing low or while busy has no effect
	// the engine is two states: idle, and one apply cycle in which the table is
	// searched and written. pending therefore stands for exactly one cycle.
	// software may poll either the command bit or the status word; both show pending.
	// a request while busy is dropped rather than queued, since software must
	// wait for pending to clear before the next command anyway.
	assign make_start = wr_access && sel_cmd && pwdata[ATW_CMD_MAKE_BIT] && (state_q == ATW_ST_IDLE);
	assign make_pending = (state_q != ATW_ST_IDLE);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ATW_ST_IDLE: begin
				if (make_start) begin
					state_d = ATW_ST_APPLY;
				end
			end
			ATW_ST_APPLY: state_d = ATW_ST_IDLE;
			default: state_d = ATW_ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ATW_ST_IDLE;
			cap_mac_q <= '0;
			cap_ctrl_q <= '0;
		end else begin
			state_q <= state_d;
			if (make_start) begin
				cap_mac_q <= {high_q[ATW_MAC_HI_MSB:0], mac_low_q};
				cap_ctrl_q <= high_q[ATW_HIGH_W-1:ATW_PORT_LSB];
			end
		end
	end

	// ==========================================================
	// table storage and per-entry match terms
	// placement: a matching valid entry is always reused, so a mac address can
	// never appear twice; otherwise the lowest free slot is taken.
	// limitation: with a full table a new address is refused and the full flag
	// is raised; nothing is evicted, so software must delete entries to make room.
	// learning from the source port is not part of this block; only refresh is.
	logic [ATW_MAC_W-1:0] ent_mac_q [TABLE_DEPTH];
	logic [ATW_HIGH_W-1:ATW_PORT_LSB] ent_ctrl_q [TABLE_DEPTH];
	logic [TABLE_DEPTH-1:0] hit_make;
	logic [TABLE_DEPTH-1:0] hit_sa;
	logic [TABLE_DEPTH-1:0] hit_da;
	logic [TABLE_DEPTH-1:0] free_vec;
	logic age_tick;
	logic apply;
	logic match_any;
	logic free_any;
	logic wr_en;
	logic [IDX_W-1:0] match_idx;
	logic [IDX_W-1:0] free_idx;
	logic [IDX_W-1:0] wr_idx;
	logic [IDX_W-1:0] da_idx;

	// lowest set index of a vector
	function automatic logic [IDX_W-1:0] first_set(input logic [TABLE_DEPTH-1:0] vec);
		logic [IDX_W-1:0] idx;
		idx = '0;
		for (int i = TABLE_DEPTH - 1; i >= 0; i--) begin
			if (vec[i]) begin
				idx = IDX_W'(i);
			end
		end
		return idx;
	endfunction

	atw_age_tick #(
		.PERIOD(AGE_STEP_CYCLES)
	) u_age_tick (
		.pclk(pclk),
		.presetn(presetn),
		.tick(age_tick)
	);

	// update a match, else take a free slot; a clear valid never claims a slot
	assign apply = (state_q == ATW_ST_APPLY);
	assign match_any = |hit_make;
	assign free_any = |free_vec;
	assign match_idx = first_set(hit_make);
	assign free_idx = first_set(free_vec);
	assign wr_en = apply && (match_any || (cap_ctrl_q[ATW_VALID_BIT] && free_any));
	assign wr_idx = match_any ? match_idx : free_idx;
	assign da_idx = first_set(hit_da);

	genvar e;
	generate
		for (e = 0; e < TABLE_DEPTH; e++) begin : g_entry
			logic ent_valid;
			logic ent_static;
			logic [1:0] ent_age;

			assign ent_valid = ent_ctrl_q[e][ATW_VALID_BIT];
			assign ent_static = ent_ctrl_q[e][ATW_STATIC_BIT];
			assign ent_age = {ent_ctrl_q[e][ATW_AGE1_BIT], ent_ctrl_q[e][ATW_AGE0_BIT]};
			assign hit_make[e] = ent_valid && (ent_mac_q[e] == cap_mac_q);
			assign hit_sa[e] = ent_valid && (ent_mac_q[e] == sa_mac);
			assign hit_da[e] = ent_valid && (ent_mac_q[e] == da_mac);
			assign free_vec[e] = !ent_valid;

			// command write beats learning refresh, which beats the aging step
			// aging counts down 11, 10, 01, 00 and removes the entry on the step
			// after 00, so a fresh entry lives three to four steps; with the
			// default step that lands inside the five to ten minute window.
			// a refresh in the same cycle as a step wins, so an active address
			// is never dropped by an unlucky coincidence of the two.
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ent_mac_q[e] <= '0;
					ent_ctrl_q[e] <= '0;
				end else if (wr_en && (wr_idx == IDX_W'(e))) begin
					ent_mac_q[e] <= cap_mac_q;
					ent_ctrl_q[e] <= cap_ctrl_q;
				end else if (sa_valid && hit_sa[e] && !ent_static) begin
					ent_ctrl_q[e][ATW_AGE1_BIT] <= ATW_AGE_FULL[1];
					ent_ctrl_q[e][ATW_AGE0_BIT] <= ATW_AGE_FULL[0];
				end else if (age_tick && ent_valid && !ent_static) begin
					if (ent_age == ATW_AGE_EXPIRED) begin
						ent_ctrl_q[e][ATW_VALID_BIT] <= 1'b0;
					end else begin
						ent_ctrl_q[e][ATW_AGE1_BIT] <= ent_age[1] & ent_age[0];
						ent_ctrl_q[e][ATW_AGE0_BIT] <= !ent_age[0];
					end
				end
			end
		end
	endgenerate

	// table full: new entry refused; cleared by the next command start
	// set and clear can never meet: set only in apply, clear only from idle,
	// so no priority between them is needed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			full_q <= 1'b0;
		end else if (apply && cap_ctrl_q[ATW_VALID_BIT] && !match_any && !free_any) begin
			full_q <= 1'b1;
		end else if (make_start) begin
			full_q <= 1'b0;
		end
	end

	// ==========================================================
	// destination lookup, answered one cycle after the request
	// lowest matching index wins, though uniqueness of addresses makes ties
	// impossible in normal use. a make applying in the same cycle is not seen
	// by that lookup; it shows from the next request on.
	// override and discard only mean something for permanent entries; for the
	// others the same bits are the aging timer and must not leak out.
	// priority valid is raised only when both the entry and the global switch allow it; the priority field follows every hit.
	logic [ATW_HIGH_W-1:ATW_PORT_LSB] da_ctrl;
	logic da_any;
	logic da_static;
	logic [2:0] da_mask_w;

	assign da_any = |hit_da;
	assign da_ctrl = ent_ctrl_q[da_idx];
	assign da_static = da_ctrl[ATW_STATIC_BIT];

	atw_port_decode u_port_decode (
		.code(da_ctrl[ATW_PORT_MSB:ATW_PORT_LSB]),
		.port_mask(da_mask_w),
		.reserved()
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			da_result_valid <= 1'b0;
			da_hit <= 1'b0;
			da_port_mask <= 3'h0;
			da_override <= 1'b0;
			da_discard <= 1'b0;
			da_priority_valid <= 1'b0;
			da_priority <= 3'h0;
		end else begin
			da_result_valid <= da_valid;
			da_hit <= da_valid && da_any;
			da_port_mask <= (da_valid && da_any) ? da_mask_w : 3'h0;
			da_override <= da_valid && da_any && da_static && da_ctrl[ATW_AGE1_BIT];
			da_discard <= da_valid && da_any && da_static && da_ctrl[ATW_AGE0_BIT];
			da_priority_valid <= da_valid && da_any && da_ctrl[ATW_PRI_EN_BIT] && da_pri_global_q;
			da_priority <= (da_valid && da_any) ? da_ctrl[ATW_PRI_MSB:ATW_PRI_LSB] : 3'h0;
		end
	end
endmodule
